// file: core/clock_fault_status_monitor.sv
`timescale 1ns/10ps

// What this block does
// - reference for deviation is selectable: oscillator or any one of four inputs
// - final deviation flag combines precise and fast monitor results
// - precise and fast monitors can each be disabled on their own
// - live deviation status tracks state, sticky deviation bit holds until cleared
// - precise window up to 511 ppm in 1/16 ppm steps
// - precise monitor has programmable hysteresis between assert and deassert
// - fast monitor flags a change beyond 1000 to 16000 ppm threshold
// - lock loss judged from phase detector frequency difference
// - separate set and clear comparators give lock status hysteresis
// - lock thresholds programmable from 0.1 ppm to 10000 ppm
// - optional timer delays clearing of lock loss
// - live lock loss and sticky lock loss until software clears
// - lock loss pin follows live monitor state, not sticky bit
// - interrupt asserts on signal loss, deviation, lock loss or holdover events
// - each status indicator has its own interrupt mask
// - interrupt returns inactive only after software clears or masks causing bit
// - live and sticky signal loss for each input and the oscillator
module clock_fault_status_monitor (
    // clock and reset
    input  wire logic                                  CLK,
    input  wire logic                                  RST_N,
    // frequency measurements, 1/16 ppm from nominal, index 4 is the oscillator
    input  wire clk_fault_pkg::meas_t                  MEAS [clk_fault_pkg::NUM_LOSS],
    input  wire logic                                  MEAS_VALID,
    // phase detector frequency difference magnitude, 0.1 ppm units
    input  wire logic [clk_fault_pkg::LOCK_THR_W-1:0]  PD_FREQ_DIFF,
    input  wire logic                                  PD_VALID,
    // external detector levels
    input  wire logic [clk_fault_pkg::NUM_LOSS-1:0]    SIGNAL_LOSS_IN,
    input  wire logic                                  HOLDOVER_IN,
    // configuration
    input  wire clk_fault_pkg::dev_cfg_t               DEV_CFG,
    input  wire clk_fault_pkg::lock_cfg_t              LOCK_CFG,
    input  wire logic [clk_fault_pkg::STATUS_W-1:0]    IRQ_MASK,
    input  wire logic [clk_fault_pkg::STATUS_W-1:0]    STICKY_CLEAR,
    // status
    output clk_fault_pkg::status_t                     LIVE_STATUS,
    output clk_fault_pkg::status_t                     STICKY_STATUS,
    output logic                                       LOCK_LOSS_ALARM,
    output logic                                       ALARM_IRQ_N
);

    // ------------------------------------------------------------
    // reference selection
    // ------------------------------------------------------------
    clk_fault_pkg::meas_t ref_meas;

    always_comb begin
        if (DEV_CFG.ref_sel < 3'(clk_fault_pkg::NUM_INPUTS)) begin
            ref_meas = MEAS[DEV_CFG.ref_sel[1:0]];
        end else begin
            ref_meas = MEAS[clk_fault_pkg::NUM_INPUTS];
        end
    end

    // ------------------------------------------------------------
    // per input deviation monitors
    // ------------------------------------------------------------
    logic [clk_fault_pkg::NUM_INPUTS-1:0] prec_flag;
    logic [clk_fault_pkg::NUM_INPUTS-1:0] next_prec_flag;
    logic [clk_fault_pkg::NUM_INPUTS-1:0] fast_flag;
    logic [clk_fault_pkg::NUM_INPUTS-1:0] next_fast_flag;
    logic [clk_fault_pkg::NUM_INPUTS-1:0] dev_live;
    clk_fault_pkg::meas_t                 prev_meas [clk_fault_pkg::NUM_INPUTS];
    clk_fault_pkg::meas_t                 next_prev_meas [clk_fault_pkg::NUM_INPUTS];
    logic                                 primed;
    logic                                 next_primed;

    // deassert point saturates at zero when hysteresis exceeds the window
    logic [clk_fault_pkg::PREC_THR_W-1:0] deassert_thr;
    logic [clk_fault_pkg::DEV_W-1:0]      fast_thr_scaled;

    always_comb begin
        if (DEV_CFG.prec_hyst > DEV_CFG.prec_assert_thr) begin
            deassert_thr = '0;
        end else begin
            deassert_thr = DEV_CFG.prec_assert_thr - DEV_CFG.prec_hyst;
        end
        fast_thr_scaled = clk_fault_pkg::DEV_W'(DEV_CFG.fast_thr)
                          << clk_fault_pkg::PPM_TO_SIXTEENTHS_SHIFT;
    end

    genvar gi;
    generate
        for (gi = 0; gi < clk_fault_pkg::NUM_INPUTS; gi++) begin : g_dev
            logic signed [clk_fault_pkg::DEV_W-1:0] rel;
            logic signed [clk_fault_pkg::DEV_W-1:0] step;
            logic        [clk_fault_pkg::DEV_W-1:0] rel_abs;
            logic        [clk_fault_pkg::DEV_W-1:0] step_abs;

            always_comb begin
                rel      = clk_fault_pkg::DEV_W'(MEAS[gi]) - clk_fault_pkg::DEV_W'(ref_meas);
                step     = clk_fault_pkg::DEV_W'(MEAS[gi]) - clk_fault_pkg::DEV_W'(prev_meas[gi]);
                rel_abs  = rel[clk_fault_pkg::DEV_W-1] ? -rel : rel;
                step_abs = step[clk_fault_pkg::DEV_W-1] ? -step : step;

                next_prev_meas[gi] = prev_meas[gi];
                next_prec_flag[gi] = prec_flag[gi];
                next_fast_flag[gi] = fast_flag[gi];
                if (MEAS_VALID) begin
                    next_prev_meas[gi] = MEAS[gi];
                    // window in 1/16 ppm; stays set until inside deassert point
                    if (rel_abs > clk_fault_pkg::DEV_W'(DEV_CFG.prec_assert_thr)) begin
                        next_prec_flag[gi] = 1'b1;
                    end else if (rel_abs <= clk_fault_pkg::DEV_W'(deassert_thr)) begin
                        next_prec_flag[gi] = 1'b0;
                    end
                    // first sample has no predecessor to compare against
                    next_fast_flag[gi] = primed && (step_abs > fast_thr_scaled);
                end
                if (!DEV_CFG.prec_en) begin
                    next_prec_flag[gi] = 1'b0;
                end
                if (!DEV_CFG.fast_en) begin
                    next_fast_flag[gi] = 1'b0;
                end
            end

            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    prev_meas[gi] <= clk_fault_pkg::MEAS_RESET;
                    prec_flag[gi] <= 1'b0;
                    fast_flag[gi] <= 1'b0;
                end else begin
                    prev_meas[gi] <= next_prev_meas[gi];
                    prec_flag[gi] <= next_prec_flag[gi];
                    fast_flag[gi] <= next_fast_flag[gi];
                end
            end

            assign dev_live[gi] = prec_flag[gi] | fast_flag[gi];
        end
    endgenerate

    always_comb begin
        next_primed = primed | MEAS_VALID;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            primed <= 1'b0;
        end else begin
            primed <= next_primed;
        end
    end

    // ------------------------------------------------------------
    // lock monitor
    // ------------------------------------------------------------
    clk_fault_pkg::lock_state_t           lk_state;
    clk_fault_pkg::lock_state_t           next_lk_state;
    logic [clk_fault_pkg::TIMER_W-1:0]    hold_cnt;
    logic [clk_fault_pkg::TIMER_W-1:0]    next_hold_cnt;
    logic                                 above_set;
    logic                                 below_clr;

    always_comb begin
        above_set     = PD_VALID && (PD_FREQ_DIFF > LOCK_CFG.set_thr);
        below_clr     = PD_VALID && (PD_FREQ_DIFF < LOCK_CFG.clr_thr);
        next_lk_state = lk_state;
        next_hold_cnt = hold_cnt;
        case (lk_state)
            clk_fault_pkg::LK_LOCKED: begin
                if (above_set) begin
                    next_lk_state = clk_fault_pkg::LK_LOST;
                end
            end
            clk_fault_pkg::LK_LOST: begin
                if (below_clr) begin
                    if (LOCK_CFG.timer_en && LOCK_CFG.timer_len != clk_fault_pkg::TIMER_RESET) begin
                        next_lk_state = clk_fault_pkg::LK_CLEARING;
                        next_hold_cnt = clk_fault_pkg::TIMER_RESET;
                    end else begin
                        next_lk_state = clk_fault_pkg::LK_LOCKED;
                    end
                end
            end
            clk_fault_pkg::LK_CLEARING: begin
                // a difference back at or above the clear point ends the wait and returns to lost
                if (PD_VALID && !below_clr) begin
                    next_lk_state = clk_fault_pkg::LK_LOST;
                end else if (hold_cnt >= LOCK_CFG.timer_len - 24'h000001) begin
                    next_lk_state = clk_fault_pkg::LK_LOCKED;
                end else begin
                    next_hold_cnt = hold_cnt + 24'h000001;
                end
            end
            default: begin
                next_lk_state = clk_fault_pkg::LK_LOST;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lk_state <= clk_fault_pkg::LK_LOST;
            hold_cnt <= clk_fault_pkg::TIMER_RESET;
        end else begin
            lk_state <= next_lk_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ------------------------------------------------------------
    // live, sticky and interrupt
    // ------------------------------------------------------------
    clk_fault_pkg::status_t live_now;
    clk_fault_pkg::status_t next_live;
    clk_fault_pkg::status_t next_sticky;
    logic                   next_irq_n;

    always_comb begin
        live_now.hold      = HOLDOVER_IN;
        live_now.lock_loss = (lk_state != clk_fault_pkg::LK_LOCKED);
        live_now.freq_dev  = dev_live;
        live_now.sig_loss  = SIGNAL_LOSS_IN;
        next_live          = live_now;
        // set wins over clear so an event in the clearing cycle survives
        next_sticky = (STICKY_STATUS & ~STICKY_CLEAR) | live_now;
        next_irq_n  = ~|(next_sticky & ~IRQ_MASK);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            LIVE_STATUS     <= clk_fault_pkg::STATUS_RESET;
            STICKY_STATUS   <= clk_fault_pkg::STATUS_RESET;
            LOCK_LOSS_ALARM <= 1'b0;
            ALARM_IRQ_N     <= 1'b1;
        end else begin
            LIVE_STATUS     <= next_live;
            STICKY_STATUS   <= next_sticky;
            LOCK_LOSS_ALARM <= live_now.lock_loss;
            ALARM_IRQ_N     <= next_irq_n;
        end
    end

endmodule // clock_fault_status_monitor

// file: core/clk_fault_pkg.sv
package clk_fault_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 4;
    localparam int NUM_LOSS   = NUM_INPUTS + 1;
    localparam int MEAS_W     = 24;
    localparam int DEV_W      = MEAS_W + 1;
    localparam int PREC_THR_W = 13;
    localparam int FAST_THR_W = 14;
    localparam int LOCK_THR_W = 17;
    localparam int TIMER_W    = 24;
    localparam int STATUS_W   = 11;

    // ------------------------------------------------------------
    // units and field positions
    // ------------------------------------------------------------
    // measurements and precise thresholds are in 1/16 ppm, fast in ppm
    localparam int PPM_TO_SIXTEENTHS_SHIFT = 4;
    localparam int LOSS_POS = 0;
    localparam int DEV_POS  = 5;
    localparam int LOCK_POS = 9;
    localparam int HOLD_POS = 10;

    // ------------------------------------------------------------
    // reference select codes
    // ------------------------------------------------------------
    localparam logic [2:0] REF_SEL_OSC = 3'h4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [STATUS_W-1:0] STATUS_RESET = 11'h000;
    localparam logic [TIMER_W-1:0]  TIMER_RESET  = 24'h000000;
    localparam logic [MEAS_W-1:0]   MEAS_RESET   = 24'h000000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic signed [MEAS_W-1:0] meas_t;

    typedef struct packed {
        logic                  hold;
        logic                  lock_loss;
        logic [NUM_INPUTS-1:0] freq_dev;
        logic [NUM_LOSS-1:0]   sig_loss;
    } status_t;

    typedef struct packed {
        logic [2:0]            ref_sel;
        logic                  prec_en;
        logic                  fast_en;
        logic [PREC_THR_W-1:0] prec_assert_thr;
        logic [PREC_THR_W-1:0] prec_hyst;
        logic [FAST_THR_W-1:0] fast_thr;
    } dev_cfg_t;

    typedef struct packed {
        logic [LOCK_THR_W-1:0] set_thr;
        logic [LOCK_THR_W-1:0] clr_thr;
        logic                  timer_en;
        logic [TIMER_W-1:0]    timer_len;
    } lock_cfg_t;

    typedef enum logic [1:0] {
        LK_LOCKED   = 2'h0,
        LK_LOST     = 2'h1,
        LK_CLEARING = 2'h3
    } lock_state_t;

endpackage

// file: dv/clk_fault_properties.sv
`timescale 1ns/10ps
module clk_fault_props (
    // clock and reset
    input wire logic                     CLK,
    input wire logic                     RST_N,
    // inputs
    input wire logic [16:0]              PD_FREQ_DIFF,
    input wire logic                     PD_VALID,
    input wire logic [4:0]               SIGNAL_LOSS_IN,
    input wire logic                     HOLDOVER_IN,
    input wire clk_fault_pkg::dev_cfg_t  DEV_CFG,
    input wire clk_fault_pkg::lock_cfg_t LOCK_CFG,
    input wire logic [10:0]              IRQ_MASK,
    input wire logic [10:0]              STICKY_CLEAR,
    // outputs
    input wire clk_fault_pkg::status_t   LIVE_STATUS,
    input wire clk_fault_pkg::status_t   STICKY_STATUS,
    input wire logic                     LOCK_LOSS_ALARM,
    input wire logic                     ALARM_IRQ_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // zeroed in reset, else the first edge after release would see stale bits
    logic [10:0] kept;
    logic [10:0] next_kept;
    always_comb next_kept = RST_N ? (STICKY_STATUS & ~STICKY_CLEAR) : 11'h000;
    always_ff @(posedge CLK) kept <= next_kept;
    sequence s_lose;
        PD_VALID && PD_FREQ_DIFF > LOCK_CFG.set_thr && LOCK_CFG.set_thr >= LOCK_CFG.clr_thr;
    endsequence
    sequence s_regain;
        PD_VALID && PD_FREQ_DIFF < LOCK_CFG.clr_thr && !LOCK_CFG.timer_en
            && LOCK_CFG.clr_thr <= LOCK_CFG.set_thr;
    endsequence
    lock_pin_live_a: assert property (LOCK_LOSS_ALARM == LIVE_STATUS.lock_loss)
        else $error("lock pin differs from live lock");
    irq_from_sticky_a: assert property (
        ALARM_IRQ_N == !(|(STICKY_STATUS & ~$past(IRQ_MASK))))
        else $error("irq level differs from unmasked sticky");
    sticky_kept_a: assert property ((kept & ~STICKY_STATUS) == 11'h000)
        else $error("sticky bit dropped without clear");
    live_in_sticky_a: assert property ((LIVE_STATUS & ~STICKY_STATUS) == 11'h000)
        else $error("live bit without sticky bit");
    live_loss_a: assert property ($past(RST_N) |-> {LIVE_STATUS.hold, LIVE_STATUS.sig_loss}
        == {$past(HOLDOVER_IN), $past(SIGNAL_LOSS_IN)})
        else $error("live loss or holdover wrong");
    lock_set_a: assert property (s_lose |=> ##1 LOCK_LOSS_ALARM)
        else $error("lock loss not raised");
    lock_clear_a: assert property (s_regain |=> ##1 !LOCK_LOSS_ALARM)
        else $error("lock loss not cleared");
    dev_off_a: assert property (
        (!DEV_CFG.prec_en && !DEV_CFG.fast_en) [*4] |-> LIVE_STATUS.freq_dev == 4'h0)
        else $error("deviation with both monitors off");
endmodule // clk_fault_props

bind clock_fault_status_monitor clk_fault_props u_props (
    .CLK, .RST_N, .PD_FREQ_DIFF, .PD_VALID, .SIGNAL_LOSS_IN, .HOLDOVER_IN, .DEV_CFG,
    .LOCK_CFG, .IRQ_MASK, .STICKY_CLEAR, .LIVE_STATUS, .STICKY_STATUS, .LOCK_LOSS_ALARM,
    .ALARM_IRQ_N
);

// file: dv/clk_source_model.sv
`timescale 1ns/10ps
module clk_source_model (
    // clock
    input  wire logic            clk,
    // measurements and phase detector
    output clk_fault_pkg::meas_t meas [clk_fault_pkg::NUM_LOSS],
    output logic                 meas_valid,
    output logic [16:0]          pd_diff,
    output logic                 pd_valid
);
    initial begin
        foreach (meas[i]) meas[i] = 24'h000000;
        meas_valid = 1'b0;
        pd_diff = 17'h1FFFF;
        pd_valid = 1'b0;
    end
    // one input offset, all others at nominal; strobe lasts one cycle
    task automatic measure(input int idx, input clk_fault_pkg::meas_t off);
        @(negedge clk);
        foreach (meas[i]) meas[i] = 24'h000000;
        meas[idx] = off;
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
    endtask
    // difference is not held after the strobe
    task automatic pd(input logic [16:0] d);
        @(negedge clk);
        pd_diff = d;
        pd_valid = 1'b1;
        @(negedge clk);
        pd_valid = 1'b0;
        pd_diff = ~d;
    endtask
endmodule // clk_source_model

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic                      clk = 1'b0;
    logic                      rst_n = 1'b0;
    logic [4:0]                sig_loss = 5'h00;
    logic                      holdover = 1'b0;
    clk_fault_pkg::dev_cfg_t   dev_cfg = '0;
    clk_fault_pkg::lock_cfg_t  lock_cfg = '0;
    logic [10:0]               irq_mask = 11'h000;
    logic [10:0]               clr = 11'h000;
    clk_fault_pkg::status_t    live;
    clk_fault_pkg::status_t    sticky;
    logic                      lock_loss_alarm;
    logic                      irq_n;
    clk_fault_pkg::meas_t      meas [clk_fault_pkg::NUM_LOSS];
    logic                      meas_valid;
    logic [16:0]               pd_diff;
    logic                      pd_valid;
    int                        mismatches = 0;
    int                        n_checks = 0;
    always #2.5 clk = ~clk;
    clk_source_model src (.clk(clk), .meas(meas), .meas_valid(meas_valid),
        .pd_diff(pd_diff), .pd_valid(pd_valid));
    clock_fault_status_monitor u_dut (.CLK(clk), .RST_N(rst_n), .MEAS(meas),
        .MEAS_VALID(meas_valid), .PD_FREQ_DIFF(pd_diff), .PD_VALID(pd_valid),
        .SIGNAL_LOSS_IN(sig_loss), .HOLDOVER_IN(holdover), .DEV_CFG(dev_cfg),
        .LOCK_CFG(lock_cfg), .IRQ_MASK(irq_mask), .STICKY_CLEAR(clr),
        .LIVE_STATUS(live), .STICKY_STATUS(sticky), .LOCK_LOSS_ALARM(lock_loss_alarm),
        .ALARM_IRQ_N(irq_n));
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic clear_all;
        @(negedge clk);
        clr = 11'h7FF;
        @(negedge clk);
        clr = 11'h000;
    endtask
    task automatic sample(input int i, input clk_fault_pkg::meas_t off);
        src.measure(i, off);
        w(2);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_lock;
        chk("lol after reset", lock_loss_alarm, 1);
        src.pd(17'h00000);
        w(3);
        chk("lol cleared", lock_loss_alarm, 0);
        chk("sticky lol", sticky.lock_loss, 1);
        chk("irq held", irq_n, 0);
        clear_all;
        chk("irq released", irq_n, 1);
        src.pd(17'h0000A);
        w(3);
        chk("lol at set thr", lock_loss_alarm, 0);
        src.pd(17'h0000B);
        w(3);
        chk("lol above set", lock_loss_alarm, 1);
        src.pd(17'h00005);
        w(3);
        chk("lol in hysteresis", lock_loss_alarm, 1);
        lock_cfg.timer_en = 1'b1;
        src.pd(17'h00000);
        w(17);
        chk("lol held by timer", lock_loss_alarm, 1);
        w(8);
        chk("lol after timer", lock_loss_alarm, 0);
        lock_cfg.timer_en = 1'b0;
        $display("lock test done");
    endtask
    task automatic t_prec;
        int i;
        dev_cfg.prec_en = 1'b1;
        for (int r = 0; r < 5; r++) begin
            dev_cfg.ref_sel = r[2:0];
            i = (r + 1) % 4;
            sample(i, 24'h0003C1);
            chk("dev over", live.freq_dev, 4'h1 << i);
            sample(i, 24'h0003A1);
            chk("dev hyst", live.freq_dev, 4'h1 << i);
            sample(i, 24'h0003A0);
            chk("dev back", live.freq_dev, 4'h0);
        end
        dev_cfg.prec_assert_thr = 13'h1FF0;
        sample(0, 24'h001FF0);
        chk("dev at max", live.freq_dev, 4'h0);
        sample(0, 24'h001FF1);
        chk("dev past max", live.freq_dev, 4'h1);
        $display("precise test done");
    endtask
    task automatic t_fast;
        dev_cfg.prec_en = 1'b0;
        dev_cfg.fast_en = 1'b1;
        sample(0, 24'h000000);
        // sticky bits left by the precise test would hide the fast event
        clear_all;
        sample(0, 24'h003E80);
        chk("fast at thr", live.freq_dev, 4'h0);
        sample(0, 24'h007D01);
        chk("fast over", live.freq_dev, 4'h1);
        sample(0, 24'h007D01);
        chk("fast steady", live.freq_dev, 4'h0);
        chk("dev sticky", sticky.freq_dev, 4'h1);
        $display("fast test done");
    endtask
    task automatic t_irq;
        int b;
        clear_all;
        for (int k = 0; k < 6; k++) begin
            b = (k < 5) ? k : 10;
            irq_mask = 11'h7FF;
            if (k < 5) sig_loss[k] = 1'b1;
            else holdover = 1'b1;
            w(2);
            chk("masked irq", irq_n, 1);
            chk("sticky loss", sticky[b], 1);
            irq_mask = ~(11'h001 << b);
            w(1);
            chk("irq raised", irq_n, 0);
            clear_all;
            chk("clear while live", irq_n, 0);
            sig_loss = 5'h00;
            holdover = 1'b0;
            w(2);
            clear_all;
            chk("irq after clear", irq_n, 1);
        end
        irq_mask = 11'h000;
        $display("irq test done");
    endtask
    initial begin
        dev_cfg.prec_assert_thr = 13'h03C0;
        dev_cfg.prec_hyst = 13'h0020;
        dev_cfg.fast_thr = 14'h03E8;
        lock_cfg.set_thr = 17'h0000A;
        lock_cfg.clr_thr = 17'h00001;
        lock_cfg.timer_len = 24'h000014;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        w(2);
        t_lock;
        t_prec;
        t_fast;
        t_irq;
        results;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        results;
    end
endmodule // tb_top
